// [fr_fault_response_handler.sv]
// Fault response handler with its management link slave
`timescale 1ns/1ps
module fr_fault_response_handler #(
  parameter logic [6:0] DEV_ADDR = fr_pkg::DEV_ADDR_RST
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic linkClk,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic alertOut,
  output logic alertOe,
  output logic gpioOut,
  output logic gpioOe,
  input wire logic runPin,
  input wire logic tempValid,
  input wire logic [15:0] tempSample,
  input wire logic otFault,
  input wire logic tonMaxFault,
  input wire logic vinOvFault,
  output logic outputEnable
);
  ////////////////////////////////////////////////////////////////////////////////
  // Link domain: reset release, pin synchronisers and bus events
  logic [1:0] linkRst_r;
  logic [1:0] sclS_r;
  logic [1:0] sdaS_r;
  logic sclD_r;
  logic sdaD_r;
  logic linkRst;
  logic scl;
  logic sda;
  logic startEv;
  logic stopEv;
  logic sclRise;
  logic sclFall;

  always_ff @(posedge linkClk or posedge reset)
    if (reset)
      linkRst_r <= 2'h3;
    else
      linkRst_r <= {linkRst_r[0], 1'b0};
  assign linkRst = linkRst_r[1];

  always_ff @(posedge linkClk or posedge reset)
    if (reset)
    begin
      sclS_r <= 2'h3;
      sdaS_r <= 2'h3;
      sclD_r <= 1'b1;
      sdaD_r <= 1'b1;
    end
    else
    begin
      sclS_r <= {sclS_r[0], sclIn};
      sdaS_r <= {sdaS_r[0], sdaIn};
      sclD_r <= sclS_r[1];
      sdaD_r <= sdaS_r[1];
    end

  assign scl = sclS_r[1];
  assign sda = sdaS_r[1];
  assign startEv = scl && sclD_r && sdaD_r && !sda;
  assign stopEv = scl && sclD_r && !sdaD_r && sda;
  assign sclRise = scl && !sclD_r;
  assign sclFall = !scl && sclD_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain: byte engine
  fr_pkg::fr_link_state_t state_r;
  fr_pkg::fr_mirror_t mirS0_r;
  fr_pkg::fr_mirror_t mirS1_r;
  fr_pkg::fr_cmd_t cmdHold_r;
  logic [3:0] bitCnt_r;
  logic [7:0] shift_r;
  logic [7:0] txShift_r;
  logic [2:0] byteIdx_r;
  logic [7:0] cmd_r;
  logic [15:0] data_r;
  logic isRead_r;
  logic rdIdx_r;
  logic acked_r;
  logic sdaDrive_r;
  logic reqTgl_r;
  logic [15:0] rdWord;
  logic [7:0] txLoad;
  fr_pkg::fr_mirror_t mirror;

  always_comb
  begin
    rdWord = 16'hffff;
    case (cmd_r)
      fr_pkg::CMD_UT_ACTION: rdWord = {8'h00, mirS1_r.action[fr_pkg::FLT_UT]};
      fr_pkg::CMD_OT_ACTION: rdWord = {8'h00, mirS1_r.action[fr_pkg::FLT_OT]};
      fr_pkg::CMD_TON_ACTION: rdWord = {8'h00, mirS1_r.action[fr_pkg::FLT_TON]};
      fr_pkg::CMD_VIN_ACTION: rdWord = {8'h00, mirS1_r.action[fr_pkg::FLT_VIN]};
      fr_pkg::CMD_PROPAGATE: rdWord = mirS1_r.propagate;
      fr_pkg::CMD_UT_LIMIT: rdWord = mirS1_r.utLimit;
      fr_pkg::CMD_RETRY_DELAY: rdWord = {8'h00, mirS1_r.retryDelay};
      fr_pkg::CMD_STATUS_BYTE: rdWord = {8'h00, mirS1_r.statusByte};
      fr_pkg::CMD_STATUS_TEMP: rdWord = {8'h00, mirS1_r.statusTemp};
      fr_pkg::CMD_OPERATION: rdWord = {8'h00, mirS1_r.operOn, 7'h00};
      default: rdWord = 16'hffff;
    endcase
    txLoad = rdIdx_r ? rdWord[15:8] : rdWord[7:0];
  end

  always_ff @(posedge linkClk or posedge linkRst)
    if (linkRst)
    begin
      state_r <= fr_pkg::LS_IDLE;
      bitCnt_r <= 4'h0;
      shift_r <= 8'h00;
      txShift_r <= 8'h00;
      byteIdx_r <= 3'h0;
      cmd_r <= 8'h00;
      data_r <= 16'h0000;
      isRead_r <= 1'b0;
      rdIdx_r <= 1'b0;
      acked_r <= 1'b0;
      sdaDrive_r <= 1'b0;
    end
    else if (startEv)
    begin
      state_r <= fr_pkg::LS_ADDR;
      bitCnt_r <= 4'h0;
      sdaDrive_r <= 1'b0;
    end
    else if (stopEv)
    begin
      state_r <= fr_pkg::LS_IDLE;
      byteIdx_r <= 3'h0;
      sdaDrive_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        fr_pkg::LS_IDLE:
          sdaDrive_r <= 1'b0;
        fr_pkg::LS_ADDR, fr_pkg::LS_WBYTE:
          if (sclRise)
          begin
            shift_r <= {shift_r[6:0], sda};
            bitCnt_r <= bitCnt_r + 4'h1;
          end
          else if (sclFall && bitCnt_r == 4'h8)
          begin
            bitCnt_r <= 4'h0;
            if (state_r == fr_pkg::LS_ADDR)
            begin
              if (shift_r[7:1] == DEV_ADDR)
              begin
                isRead_r <= shift_r[0];
                rdIdx_r <= 1'b0;
                sdaDrive_r <= 1'b1;
                state_r <= fr_pkg::LS_ADDR_ACK;
              end
              else
                state_r <= fr_pkg::LS_IDLE;
            end
            else
            begin
              if (byteIdx_r == 3'h0)
                cmd_r <= shift_r;
              else if (byteIdx_r == 3'h1)
                data_r[7:0] <= shift_r;
              else if (byteIdx_r == 3'h2)
                data_r[15:8] <= shift_r;
              if (byteIdx_r != 3'h4)
                byteIdx_r <= byteIdx_r + 3'h1;
              // Extra bytes beyond a word are refused
              sdaDrive_r <= byteIdx_r < 3'h3;
              state_r <= fr_pkg::LS_WACK;
            end
          end
        fr_pkg::LS_ADDR_ACK:
          if (sclFall)
          begin
            if (isRead_r)
            begin
              txShift_r <= txLoad;
              sdaDrive_r <= !txLoad[7];
              state_r <= fr_pkg::LS_RBYTE;
            end
            else
            begin
              sdaDrive_r <= 1'b0;
              state_r <= fr_pkg::LS_WBYTE;
            end
          end
        fr_pkg::LS_WACK:
          if (sclFall)
          begin
            sdaDrive_r <= 1'b0;
            state_r <= fr_pkg::LS_WBYTE;
          end
        fr_pkg::LS_RBYTE:
          if (sclRise)
            bitCnt_r <= bitCnt_r + 4'h1;
          else if (sclFall && bitCnt_r == 4'h8)
          begin
            bitCnt_r <= 4'h0;
            sdaDrive_r <= 1'b0;
            rdIdx_r <= !rdIdx_r;
            state_r <= fr_pkg::LS_RACK;
          end
          else if (sclFall)
          begin
            txShift_r <= {txShift_r[6:0], 1'b0};
            sdaDrive_r <= !txShift_r[6];
          end
        fr_pkg::LS_RACK:
          if (sclRise)
            acked_r <= !sda;
          else if (sclFall && acked_r)
          begin
            txShift_r <= txLoad;
            sdaDrive_r <= !txLoad[7];
            state_r <= fr_pkg::LS_RBYTE;
          end
          else if (sclFall)
            state_r <= fr_pkg::LS_IDLE;
      endcase
    end

  // A finished write is held and announced by a toggle
  always_ff @(posedge linkClk or posedge linkRst)
    if (linkRst)
    begin
      cmdHold_r <= '0;
      reqTgl_r <= 1'b0;
    end
    else if (stopEv && !isRead_r && byteIdx_r != 3'h0)
    begin
      cmdHold_r.code <= cmd_r;
      cmdHold_r.data <= data_r;
      cmdHold_r.count <= (byteIdx_r > 3'h3) ? 2'h3 : 2'(byteIdx_r - 3'h1);
      reqTgl_r <= !reqTgl_r;
    end

  // Quasi-static register view brought over bit by bit
  always_ff @(posedge linkClk or posedge linkRst)
    if (linkRst)
    begin
      mirS0_r <= '0;
      mirS1_r <= '0;
    end
    else
    begin
      mirS0_r <= mirror;
      mirS1_r <= mirS0_r;
    end

  assign sdaOut = 1'b0;
  assign sdaOe = sdaDrive_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Main domain: synchronisers and command decode
  logic [2:0] reqS_r;
  logic [1:0] runS_r;
  logic [1:0] otS_r;
  logic [1:0] tonS_r;
  logic [1:0] vinS_r;
  logic wrEv;
  logic isAction;
  logic badResp;
  logic countOk;
  logic knownCode;
  int actIdx;

  always_ff @(posedge clock or posedge reset)
    if (reset)
    begin
      reqS_r <= 3'h0;
      runS_r <= 2'h0;
      otS_r <= 2'h0;
      tonS_r <= 2'h0;
      vinS_r <= 2'h0;
    end
    else
    begin
      reqS_r <= {reqS_r[1:0], reqTgl_r};
      runS_r <= {runS_r[0], runPin};
      otS_r <= {otS_r[0], otFault};
      tonS_r <= {tonS_r[0], tonMaxFault};
      vinS_r <= {vinS_r[0], vinOvFault};
    end

  assign wrEv = reqS_r[2] ^ reqS_r[1];

  always_comb
  begin
    actIdx = 0;
    isAction = 1'b1;
    knownCode = 1'b1;
    countOk = cmdHold_r.count == 2'h1;
    case (cmdHold_r.code)
      fr_pkg::CMD_UT_ACTION: actIdx = fr_pkg::FLT_UT;
      fr_pkg::CMD_OT_ACTION: actIdx = fr_pkg::FLT_OT;
      fr_pkg::CMD_TON_ACTION: actIdx = fr_pkg::FLT_TON;
      fr_pkg::CMD_VIN_ACTION: actIdx = fr_pkg::FLT_VIN;
      default:
      begin
        isAction = 1'b0;
        case (cmdHold_r.code)
          fr_pkg::CMD_PROPAGATE, fr_pkg::CMD_UT_LIMIT: countOk = cmdHold_r.count == 2'h2;
          fr_pkg::CMD_CLEAR: countOk = cmdHold_r.count == 2'h0;
          fr_pkg::CMD_OPERATION, fr_pkg::CMD_RETRY_DELAY: countOk = cmdHold_r.count == 2'h1;
          default: knownCode = 1'b0;
        endcase
      end
    endcase
    badResp = isAction && (cmdHold_r.data[fr_pkg::RESP_MSB:fr_pkg::RESP_LSB] == fr_pkg::RESP_BAD_A
      || cmdHold_r.data[fr_pkg::RESP_MSB:fr_pkg::RESP_LSB] == fr_pkg::RESP_BAD_B);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main domain: configuration registers
  logic [fr_pkg::NUM_FAULTS-1:0][7:0] action_r;
  logic [15:0] propagate_r;
  logic [15:0] utLimit_r;
  logic [7:0] retryDelay_r;
  logic operOn_r;
  logic cml_r;
  logic wrOk;
  logic clearCmd;
  logic clearEv;

  assign wrOk = wrEv && countOk && knownCode;
  assign clearCmd = wrOk && cmdHold_r.code == fr_pkg::CMD_CLEAR;

  // Action bytes keep all eight bits; bits 2:0 steer nothing
  always_ff @(posedge clock or posedge reset)
    if (reset)
      action_r <= {fr_pkg::NUM_FAULTS{fr_pkg::ACTION_RST}};
    else if (wrOk && isAction && !badResp)
      action_r[actIdx] <= cmdHold_r.data[7:0];

  always_ff @(posedge clock or posedge reset)
    if (reset)
    begin
      propagate_r <= fr_pkg::PROPAGATE_RST;
      utLimit_r <= fr_pkg::UT_LIMIT_RST;
      retryDelay_r <= fr_pkg::RETRY_DELAY_RST;
      operOn_r <= fr_pkg::OPER_ON_RST;
    end
    else if (wrOk)
    begin
      if (cmdHold_r.code == fr_pkg::CMD_PROPAGATE)
        propagate_r <= cmdHold_r.data;
      if (cmdHold_r.code == fr_pkg::CMD_UT_LIMIT)
        utLimit_r <= cmdHold_r.data;
      if (cmdHold_r.code == fr_pkg::CMD_RETRY_DELAY)
        retryDelay_r <= cmdHold_r.data[7:0];
      if (cmdHold_r.code == fr_pkg::CMD_OPERATION)
        operOn_r <= cmdHold_r.data[fr_pkg::OPER_ON_BIT];
    end

  // Bad response codes, wrong byte counts and unknown codes; set beats clear
  always_ff @(posedge clock or posedge reset)
    if (reset)
      cml_r <= 1'b0;
    else if (wrEv && (badResp || !countOk || !knownCode))
      cml_r <= 1'b1;
    else if (clearEv)
      cml_r <= 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // Main domain: fault detection, flags and responses
  logic [fr_pkg::NUM_FAULTS-1:0] cond;
  logic [fr_pkg::NUM_FAULTS-1:0] flag_r;
  logic [fr_pkg::NUM_FAULTS-1:0] shut_r;
  logic [fr_pkg::NUM_FAULTS-1:0] shutSet;
  logic [fr_pkg::NUM_FAULTS-1:0] retryAll;
  logic [fr_pkg::NUM_FAULTS-1:0] active;
  logic [fr_pkg::NUM_FAULTS-1:0] propMask;
  logic utDet_r;
  logic onCmdD_r;
  logic onCmd;
  logic onRise;
  logic retryPend;
  logic retryDone;
  logic [15:0] waitCnt_r;
  logic [15:0] waitTarget;

  // Decision taken on every converter sample, well inside the 80ms budget
  always_ff @(posedge clock or posedge reset)
    if (reset)
      utDet_r <= 1'b0;
    else if (tempValid)
      utDet_r <= $signed(tempSample) < $signed(utLimit_r);

  assign cond = {vinS_r[1], tonS_r[1], otS_r[1], utDet_r};
  assign propMask = {1'b0, propagate_r[fr_pkg::PROP_TON], propagate_r[fr_pkg::PROP_OT],
    propagate_r[fr_pkg::PROP_UT]};
  assign onCmd = runS_r[1] && operOn_r;
  assign onRise = onCmd && !onCmdD_r;
  assign clearEv = clearCmd || onRise;

  always_ff @(posedge clock or posedge reset)
    if (reset)
      onCmdD_r <= 1'b0;
    else
      onCmdD_r <= onCmd;

  genvar gi;
  generate
    for (gi = 0; gi < fr_pkg::NUM_FAULTS; gi++)
    begin : g_fault
      assign active[gi] = action_r[gi][fr_pkg::RESP_MSB:fr_pkg::RESP_LSB] != fr_pkg::RESP_IGNORE;
      assign shutSet[gi] = cond[gi] && onCmd &&
        action_r[gi][fr_pkg::RESP_MSB:fr_pkg::RESP_LSB] == fr_pkg::RESP_SHUT;
      assign retryAll[gi] = action_r[gi][fr_pkg::RETRY_MSB:fr_pkg::RETRY_LSB] == fr_pkg::RETRY_FOREVER;

      // Latched flag whatever the response; a new event beats a clear
      always_ff @(posedge clock or posedge reset)
        if (reset)
          flag_r[gi] <= 1'b0;
        else
          flag_r[gi] <= cond[gi] || (flag_r[gi] && !clearEv);

      always_ff @(posedge clock or posedge reset)
        if (reset)
          shut_r[gi] <= 1'b0;
        else if (shutSet[gi])
          shut_r[gi] <= 1'b1;
        else if (!onCmd)
          shut_r[gi] <= 1'b0;
        else if (retryAll[gi])
        begin
          if (retryDone)
            shut_r[gi] <= 1'b0;
        end
        else if (clearEv)
          shut_r[gi] <= 1'b0;
    end
  endgenerate

  // Retries pause while any latched shutdown forbids them
  assign retryPend = |(shut_r & retryAll) && !(|(shut_r & ~retryAll));
  assign waitTarget = 16'(32'(retryDelay_r) * fr_pkg::RETRY_UNIT_CYC);
  assign retryDone = retryPend && waitCnt_r >= waitTarget;

  always_ff @(posedge clock or posedge reset)
    if (reset)
      waitCnt_r <= 16'h0000;
    else if (!retryPend || retryDone)
      waitCnt_r <= 16'h0000;
    else
      waitCnt_r <= waitCnt_r + 16'h0001;

  ////////////////////////////////////////////////////////////////////////////////
  // Main domain: pins and status view
  logic outEn_r;
  logic alert_r;
  logic gpio_r;

  always_ff @(posedge clock or posedge reset)
    if (reset)
    begin
      outEn_r <= 1'b0;
      alert_r <= 1'b0;
      gpio_r <= 1'b0;
    end
    else
    begin
      outEn_r <= onCmd && !(|shut_r) && !(|shutSet);
      alert_r <= |flag_r || cml_r;
      gpio_r <= |(flag_r & propMask & active);
    end

  assign outputEnable = outEn_r;
  assign alertOut = 1'b0;
  assign alertOe = alert_r;
  assign gpioOut = 1'b0;
  assign gpioOe = gpio_r;

  always_comb
  begin
    mirror = '0;
    mirror.action = action_r;
    mirror.propagate = propagate_r;
    mirror.utLimit = utLimit_r;
    mirror.retryDelay = retryDelay_r;
    mirror.operOn = operOn_r;
    mirror.statusByte[fr_pkg::STB_TEMP] = flag_r[fr_pkg::FLT_UT] || flag_r[fr_pkg::FLT_OT];
    mirror.statusByte[fr_pkg::STB_CML] = cml_r;
    mirror.statusTemp[fr_pkg::STT_UT] = flag_r[fr_pkg::FLT_UT];
    mirror.statusTemp[fr_pkg::STT_OT] = flag_r[fr_pkg::FLT_OT];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_UT_SUMMARY: assert property (@(posedge clock) disable iff (reset)
    cond[fr_pkg::FLT_UT] |=> mirror.statusByte[fr_pkg::STB_TEMP])
    else $error("Undertemperature did not set the temperature summary bit");
  AST_UT_FLAG: assert property (@(posedge clock) disable iff (reset)
    cond[fr_pkg::FLT_UT] |=> mirror.statusTemp[fr_pkg::STT_UT])
    else $error("Undertemperature did not set its status flag");
  AST_ALERT: assert property (@(posedge clock) disable iff (reset)
    |cond |=> ##1 alertOe)
    else $error("Fault did not drive alert");
  AST_IGNORE: assert property (@(posedge clock) disable iff (reset)
    $rose(shut_r[fr_pkg::FLT_UT]) |-> $past(action_r[fr_pkg::FLT_UT][7:6]) == fr_pkg::RESP_SHUT)
    else $error("Shutdown without shutdown response");
  AST_CML: assert property (@(posedge clock) disable iff (reset)
    wrEv && badResp |=> cml_r && $stable(action_r))
    else $error("Unsupported response write not rejected with CML");
  AST_SHUT: assert property (@(posedge clock) disable iff (reset)
    |shutSet |=> !outputEnable ##1 !outputEnable)
    else $error("Output not disabled on shutdown response");
  AST_CLEAR: assert property (@(posedge clock) disable iff (reset)
    $fell(flag_r[fr_pkg::FLT_UT]) |-> $past(clearEv) && !$past(cond[fr_pkg::FLT_UT]))
    else $error("Fault flag cleared without a clearing event");
  AST_NORETRY: assert property (@(posedge clock) disable iff (reset)
    shut_r[fr_pkg::FLT_UT] && !retryAll[fr_pkg::FLT_UT] && onCmd && !clearEv
    |=> shut_r[fr_pkg::FLT_UT])
    else $error("No-retry shutdown released by itself");
  AST_DELAY: assert property (@(posedge clock) disable iff (reset)
    retryDone |-> waitCnt_r == waitTarget)
    else $error("Restart not spaced by the retry delay");
  AST_GPIO: assert property (@(posedge clock) disable iff (reset)
    flag_r[fr_pkg::FLT_UT] && propagate_r[fr_pkg::PROP_UT] && active[fr_pkg::FLT_UT] |=> gpioOe)
    else $error("Undertemperature not propagated to the pin");
  // Pin demand rebuilt from the raw fields, independent of the mask vectors
  logic propWant;
  assign propWant = flag_r[fr_pkg::FLT_UT] && propagate_r[fr_pkg::PROP_UT]
    && action_r[fr_pkg::FLT_UT][7:6] != fr_pkg::RESP_IGNORE
    || flag_r[fr_pkg::FLT_OT] && propagate_r[fr_pkg::PROP_OT]
    && action_r[fr_pkg::FLT_OT][7:6] != fr_pkg::RESP_IGNORE
    || flag_r[fr_pkg::FLT_TON] && propagate_r[fr_pkg::PROP_TON]
    && action_r[fr_pkg::FLT_TON][7:6] != fr_pkg::RESP_IGNORE;
  AST_PROP_GATE: assert property (@(posedge clock) disable iff (reset)
    gpioOe |-> $past(propWant))
    else $error("Pin pulled for a fault without active response");

  COV_RETRY: cover property (@(posedge clock) disable iff (reset) retryDone);
  COV_UT_SHUT: cover property (@(posedge clock) disable iff (reset) shutSet[fr_pkg::FLT_UT]);
  COV_CLEAR: cover property (@(posedge clock) disable iff (reset) clearCmd && |flag_r);
  COV_WRITE: cover property (@(posedge clock) disable iff (reset) wrOk && isAction);
endmodule : fr_fault_response_handler

// [fr_fault_response_handler_tb.sv]
// Self-checking bench for the fault response handler
`timescale 1ns/1ps
module fr_fault_response_handler_tb;
  logic clock = 1'b0, reset = 1'b1, linkClk = 1'b0, runPin = 1'b1, tempValid = 1'b0;
  logic [15:0] tempSample = 16'h0000;
  logic otFault = 1'b0, tonMaxFault = 1'b0, vinOvFault = 1'b0;
  logic [15:0] v;
  logic scl, hostLow, sdaOut, sdaOe, alertOut, alertOe, gpioOut, gpioOe, outputEnable;
  int errCount = 0;
  int nTests = 0;
  wire sdaLine = ~(hostLow | sdaOe);
  always #2.5 clock = ~clock;
  initial #1.3 forever #3 linkClk = ~linkClk;
  fr_host_model fr_host_model_inst (.scl(scl), .sdaLow(hostLow), .sdaLine(sdaLine));
  fr_fault_response_handler fr_fault_response_handler_inst (.clock(clock), .reset(reset),
    .linkClk(linkClk), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .alertOut(alertOut), .alertOe(alertOe), .gpioOut(gpioOut), .gpioOe(gpioOe),
    .runPin(runPin), .tempValid(tempValid), .tempSample(tempSample), .otFault(otFault),
    .tonMaxFault(tonMaxFault), .vinOvFault(vinOvFault), .outputEnable(outputEnable));
  task automatic testDone();
    $display("comparisons %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : testDone
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      errCount++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic io(input logic [7:0] c, input logic rdOp, input int n, input logic [15:0] d);
    fr_host_model_inst.xfer(c, rdOp, n, d, v);
  endtask : io
  task automatic sample(input logic [15:0] t);
    @(posedge clock);
    tempValid <= 1'b1;
    tempSample <= t;
    @(posedge clock);
    tempValid <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : sample
  task automatic waitOut(input logic e, input int lim);
    int i;
    for (i = 0; i < lim && outputEnable !== e; i++) @(posedge clock);
    check(outputEnable, e);
    if (i == lim) testDone();
  endtask : waitOut
  task automatic testReset();
    waitOut(1'b1, 50);
    io(8'h54, 1'b1, 1, 16'h0000);
    check(v, 16'h00b8);
    io(8'hd2, 1'b1, 2, 16'h0000);
    check(v, 16'h2993);
    io(8'hd2, 1'b0, 2, 16'h0100);
    io(8'hd2, 1'b1, 2, 16'h0000);
    check(v, 16'h0100);
    $display("reset values test done");
  endtask : testReset
  task automatic testIgnore();
    io(8'h54, 1'b0, 1, 16'h0000);
    sample(16'h8000);
    check(alertOe, 1'b1);
    check(outputEnable, 1'b1);
    check(gpioOe, 1'b0);
    io(8'h78, 1'b1, 1, 16'h0000);
    check(v[2], 1'b1);
    io(8'h7d, 1'b1, 1, 16'h0000);
    check(v[4], 1'b1);
    // Sample equal to the threshold is not a fault
    sample(16'hffd8);
    io(8'h03, 1'b0, 0, 16'h0000);
    check(alertOe, 1'b0);
    io(8'h7d, 1'b1, 1, 16'h0000);
    check(v[4], 1'b0);
    $display("ignore test done");
  endtask : testIgnore
  task automatic testBad();
    for (int k = 1; k < 4; k += 2)
    begin
      io(8'h54, 1'b0, 1, 16'(k << 6));
      io(8'h78, 1'b1, 1, 16'h0000);
      check(v[1], 1'b1);
      io(8'h54, 1'b1, 1, 16'h0000);
      check(v, 16'h0000);
      io(8'h03, 1'b0, 0, 16'h0000);
    end
    $display("unsupported response test done");
  endtask : testBad
  task automatic testShutdown();
    io(8'h54, 1'b0, 1, 16'h0087);
    sample(16'h8000);
    check(outputEnable, 1'b0);
    check(gpioOe, 1'b1);
    sample(16'h0000);
    repeat (300) @(posedge clock);
    check(outputEnable, 1'b0);
    runPin <= 1'b0;
    repeat (10) @(posedge clock);
    runPin <= 1'b1;
    waitOut(1'b1, 50);
    repeat (4) @(posedge clock);
    check(alertOe, 1'b0);
    $display("shutdown test done");
  endtask : testShutdown
  task automatic testRetry();
    io(8'hea, 1'b0, 1, 16'h0001);
    io(8'h54, 1'b0, 1, 16'h00b8);
    sample(16'h8000);
    sample(16'h0000);
    check(outputEnable, 1'b0);
    repeat (150) @(posedge clock);
    check(outputEnable, 1'b0);
    waitOut(1'b1, 150);
    $display("retry test done");
  endtask : testRetry
  task automatic testPins();
    io(8'h03, 1'b0, 0, 16'h0000);
    io(8'hd2, 1'b0, 2, 16'h2100);
    check(alertOe, 1'b0);
    @(posedge clock);
    otFault <= 1'b1;
    tonMaxFault <= 1'b1;
    repeat (6) @(posedge clock);
    check(outputEnable, 1'b0);
    check(alertOe, 1'b1);
    check(gpioOe, 1'b1);
    check({sdaOut, alertOut, gpioOut}, 3'h0);
    otFault <= 1'b0;
    tonMaxFault <= 1'b0;
    io(8'h7d, 1'b1, 1, 16'h0000);
    check(v, 16'h0080);
    waitOut(1'b1, 300);
    io(8'h03, 1'b0, 0, 16'h0000);
    @(posedge clock);
    vinOvFault <= 1'b1;
    repeat (6) @(posedge clock);
    check(outputEnable, 1'b0);
    check(alertOe, 1'b1);
    vinOvFault <= 1'b0;
    waitOut(1'b1, 300);
    $display("fault pin test done");
  endtask : testPins
  initial
  begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    repeat (10) @(posedge clock);
    testReset();
    testIgnore();
    testBad();
    testShutdown();
    testRetry();
    testPins();
    testDone();
  end
endmodule : fr_fault_response_handler_tb

// [fr_host_model.sv]
// SMBus host model for the management link
`timescale 1ns/1ps
module fr_host_model (
  output logic scl,
  output logic sdaLow,
  input wire logic sdaLine
);
  localparam int T = 30;
  logic r;
  initial
  begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic bitx(input logic b, output logic s);
    sdaLow = ~b;
    #T scl = 1'b1;
    #T s = sdaLine;
    scl = 1'b0;
    #T;
  endtask : bitx
  task automatic start();
    sdaLow = 1'b0;
    #T scl = 1'b1;
    #T sdaLow = 1'b1;
    #T scl = 1'b0;
    #T;
  endtask : start
  task automatic sendByte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'b1, r);
  endtask : sendByte
  task automatic xfer(input logic [7:0] c, input logic rdOp, input int n,
    input logic [15:0] d, output logic [15:0] v);
    v = 16'h0000;
    start();
    sendByte({fr_pkg::DEV_ADDR_RST, 1'b0});
    sendByte(c);
    if (rdOp)
    begin
      start();
      sendByte({fr_pkg::DEV_ADDR_RST, 1'b1});
    end
    // Low byte first, last read byte not acknowledged
    for (int i = 0; i < 8 * n; i++)
    begin
      bitx(rdOp | d[i ^ 7], v[i ^ 7]);
      if (i % 8 == 7) bitx(~rdOp | (i == 8 * n - 1), r);
    end
    sdaLow = 1'b1;
    #T scl = 1'b1;
    #T sdaLow = 1'b0;
    #300;
  endtask : xfer
endmodule : fr_host_model

// [fr_pkg.sv]
// Constants, layouts and types shared by the fault response handler
package fr_pkg;
  localparam int NUM_FAULTS = 4;
  localparam int FLT_UT = 0;
  localparam int FLT_OT = 1;
  localparam int FLT_TON = 2;
  localparam int FLT_VIN = 3;
  // Command codes on the management link
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_CLEAR = 8'h03;
  localparam logic [7:0] CMD_OT_ACTION = 8'h50;
  localparam logic [7:0] CMD_UT_LIMIT = 8'h53;
  localparam logic [7:0] CMD_UT_ACTION = 8'h54;
  localparam logic [7:0] CMD_VIN_ACTION = 8'h56;
  localparam logic [7:0] CMD_TON_ACTION = 8'h63;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] CMD_STATUS_TEMP = 8'h7d;
  localparam logic [7:0] CMD_PROPAGATE = 8'hd2;
  localparam logic [7:0] CMD_RETRY_DELAY = 8'hea;
  // Values after reset
  localparam logic [7:0] ACTION_RST = 8'hb8;
  localparam logic [15:0] PROPAGATE_RST = 16'h2993;
  localparam logic [15:0] UT_LIMIT_RST = 16'hffd8;
  localparam logic [7:0] RETRY_DELAY_RST = 8'h0a;
  localparam logic OPER_ON_RST = 1'b1;
  // Field positions
  localparam int RESP_MSB = 7;
  localparam int RESP_LSB = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int OPER_ON_BIT = 7;
  localparam int STB_TEMP = 2;
  localparam int STB_CML = 1;
  localparam int STT_OT = 7;
  localparam int STT_UT = 4;
  localparam int PROP_UT = 8;
  localparam int PROP_OT = 7;
  localparam int PROP_TON = 13;
  // Encodings
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_BAD_A = 2'h1;
  localparam logic [1:0] RESP_SHUT = 2'h2;
  localparam logic [1:0] RESP_BAD_B = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  // Timing and device address
  localparam int CLK_MHZ = 200;
  localparam int TEMP_RESPONSE_MS = 80;
  localparam int RETRY_UNIT_US = 1;
  localparam int RETRY_UNIT_CYC = RETRY_UNIT_US * CLK_MHZ;
  localparam logic [6:0] DEV_ADDR_RST = 7'h30;

  typedef struct packed {
    logic [7:0] code;
    logic [15:0] data;
    logic [1:0] count;
  } fr_cmd_t;

  typedef struct packed {
    logic [NUM_FAULTS-1:0][7:0] action;
    logic [15:0] propagate;
    logic [15:0] utLimit;
    logic [7:0] retryDelay;
    logic [7:0] statusByte;
    logic [7:0] statusTemp;
    logic operOn;
  } fr_mirror_t;

  typedef enum {LS_IDLE, LS_ADDR, LS_ADDR_ACK, LS_WBYTE, LS_WACK, LS_RBYTE, LS_RACK} fr_link_state_t;
endpackage : fr_pkg

// [fr_pkg_unused_guard.sv]
// Intentionally empty
`timescale 1ns/1ps
